//--- common/ctu_params.svh
// Offsets, reset values and fixed widths of the charge timing unit
`ifndef CTU_PARAMS_SVH
`define CTU_PARAMS_SVH

`define CTU_ADR_W 8
`define CTU_DAT_W 32
`define CTU_SEL_W 4
`define CTU_REG_W 16

`define CTU_ADDR_CTRL_LOW 8'h00
`define CTU_ADDR_CTRL_HIGH 8'h04
`define CTU_ADDR_STATUS 8'h08

`define CTU_CTRL_LOW_RESET 16'h0000
`define CTU_CTRL_HIGH_RESET 16'h0000
`define CTU_CTRL_LOW_MASK 16'hBFFF
`define CTU_CTRL_HIGH_MASK 16'hFFFC

`define CTU_EXT_PINS 13
`define CTU_COMPS 3
`define CTU_ASYNC_W 16
`define CTU_SRC_CODES 16
`define CTU_SEL_W_SRC 4
`define CTU_SEL_COMP2 4'hE

`define CTU_TRIM_W 6
`define CTU_TRIM_UNLISTED 6'h20
`define CTU_TRIM_MAX_NEG 6'h21

`define CTU_STAT_PULSE 0
`define CTU_STAT_SOURCE_ON 1
`define CTU_STAT_GROUNDED 2
`define CTU_STAT_HALTED 3
`define CTU_STAT_AUTO_GROUND 4
`define CTU_STAT_W 5

`endif

//--- common/ctu_pkg.sv
// Types shared by the charge timing unit files
`include "ctu_params.svh"

package ctu_pkg;

    typedef struct packed {
        logic unit_enable;
        logic reserved_14;
        logic idle_stop;
        logic delay_pulse_enable;
        logic edge_gate;
        logic edge_order_enforce;
        logic source_ground;
        logic trigger_out_enable;
        logic [`CTU_TRIM_W-1:0] current_trim;
        logic [1:0] current_range;
    } ctu_ctrl_low_t;

    typedef struct packed {
        logic sensitivity;
        logic polarity;
        logic [`CTU_SEL_W_SRC-1:0] source;
    } ctu_edge_cfg_t;

    typedef struct packed {
        ctu_edge_cfg_t first_cfg;
        logic second_edge_seen;
        logic first_edge_seen;
        ctu_edge_cfg_t second_cfg;
        logic [1:0] reserved_low;
    } ctu_ctrl_high_t;

    typedef enum logic [3:0] {
        CTU_RANGE_BASE = 4'h1,
        CTU_RANGE_X10 = 4'h2,
        CTU_RANGE_X100 = 4'h4,
        CTU_RANGE_X1000 = 4'h8
    } ctu_range_t;

    typedef struct packed {
        logic unit_active;
        logic source_on;
        logic source_grounded;
        logic route_comp2_b;
        ctu_range_t range;
        logic signed [`CTU_TRIM_W-1:0] trim;
    } ctu_analog_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [`CTU_ADR_W-1:0] adr;
        logic [`CTU_SEL_W-1:0] sel;
        logic [`CTU_DAT_W-1:0] dat;
    } ctu_wb_req_t;

endpackage

//--- hdl/ctu_sync2.sv
// Two-flop synchroniser for the asynchronous edge sources
`timescale 1ns/1ps
`default_nettype none
`include "ctu_params.svh"

module ctu_sync2 (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_sync_n,
    // Levels
    input wire logic [`CTU_ASYNC_W-1:0] async_in,
    output logic [`CTU_ASYNC_W-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < `CTU_ASYNC_W; i = i + 1)
        begin : g_bit
            logic stage1;
            always_ff @(posedge clock or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                begin
                    stage1 <= 1'b0;
                    sync_out[i] <= 1'b0;
                end
                else
                begin
                    stage1 <= async_in[i];
                    sync_out[i] <= stage1;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

//--- hdl/ctu_edge_chan.sv
// One edge channel: source select, polarity and sensitivity detection
`timescale 1ns/1ps
`default_nettype none
`include "ctu_params.svh"

module ctu_edge_chan (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_sync_n,
    // Candidate levels and configuration
    input wire logic [`CTU_SRC_CODES-1:0] levels,
    input wire ctu_pkg::ctu_edge_cfg_t cfg,
    // Detection
    output logic hit
);

    logic level;
    logic prev;
    logic primed;

    assign level = levels[cfg.source];

    // Primed blocks a false edge from the reset value of prev
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            prev <= 1'b0;
            primed <= 1'b0;
        end
        else
        begin
            prev <= level;
            primed <= 1'b1;
        end
    end

    always_comb
    begin
        if (cfg.sensitivity)
            hit = primed && (cfg.polarity ? (level && !prev) : (!level && prev));
        else
            hit = (level == cfg.polarity);
    end

endmodule
`default_nettype wire

//--- hdl/ctu_charge_timing_unit.sv
// Charge timing unit control, edge sequencing and Wishbone registers
//
// Behaviour
// - Whole unit works only while unit_enable (bit 15) is one; range, trim and route_comp2_b still follow their bits while it is zero.
// - With idle_stop (bit 13) set, unit halts while the device idles.
// - delay_pulse_enable (bit 12) turns edge delay pulse mode on or off.
// - Edges reach detection only while edge_gate (bit 11) is one.
// - With edge_order_enforce (bit 10), second edge needs a recorded first edge.
// - source_ground (bit 9) ties the current source output to ground.
// - Trigger output is driven only while trigger_out_enable (bit 8) is one.
// - Trim bits 7..2 are a signed offset around nominal current.
// - Range 01 base, 10 ten, 11 hundred, 00 thousand times base.
// - Pulse width equals interval from first to second edge.
// - Edges come from internal peripherals and thirteen external pins.
// - Pulse edges come from edge events; pin and comparator sources pass a two-flop synchroniser first.
// - Delay mode routes the current source to comparator 2 input B.
// - Delay mode starts charging on a qualified first edge.
// - Delay mode pulse pin high from first edge until comparator 2 trips.
// - Comparator 2 trip stops charging and grounds the source automatically.
// - Per-channel edge seen bits set by hardware; writes steer the source.
// - Per channel sensitivity: one is edge, zero is level.
// - Per channel polarity: one rising, zero falling.
// - Per channel 4-bit source code, 0000 timer, 1111 comparator 3.
`timescale 1ns/1ps
`default_nettype none
`include "ctu_params.svh"

module ctu_charge_timing_unit (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Wishbone slave
    input wire ctu_pkg::ctu_wb_req_t wb_req,
    output logic [`CTU_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Power management, same clock
    input wire logic idle_mode,
    // Internal edge sources, same clock
    input wire logic timer1_event,
    input wire logic ccp1_event,
    input wire logic ccp2_event,
    input wire logic clc1_out,
    input wire logic clc2_out,
    // Asynchronous edge sources
    input wire logic [`CTU_COMPS-1:0] comparator_out,
    input wire logic [`CTU_EXT_PINS-1:0] external_edge_input,
    // Pulse, trigger and analog steering
    output logic pulse_out_pin,
    output logic trigger_out,
    output var ctu_pkg::ctu_analog_t analog_ctl
);

    logic [1:0] rst_pipe;
    logic rst_sync_n;
    ctu_pkg::ctu_ctrl_low_t ctrl_low;
    ctu_pkg::ctu_edge_cfg_t first_cfg;
    ctu_pkg::ctu_edge_cfg_t second_cfg;
    ctu_pkg::ctu_edge_cfg_t second_cfg_eff;
    logic first_edge_seen;
    logic second_edge_seen;
    logic auto_ground;
    logic [`CTU_ASYNC_W-1:0] async_sync;
    logic [`CTU_COMPS-1:0] comp_s;
    logic [`CTU_EXT_PINS-1:0] ext_s;
    logic [`CTU_SRC_CODES-1:0] first_levels;
    logic [`CTU_SRC_CODES-1:0] second_levels;
    logic hit_first;
    logic hit_second;
    logic halted;
    logic active;
    logic qual_first;
    logic qual_second;
    logic wb_take;
    logic wr_low;
    logic wr_high;
    logic [`CTU_REG_W-1:0] ctrl_low_bits;
    logic [`CTU_REG_W-1:0] ctrl_high_bits;
    logic [`CTU_REG_W-1:0] byte_mask;
    logic [`CTU_STAT_W-1:0] status_bits;
    logic next_pulse;
    logic next_grounded;
    logic signed [`CTU_TRIM_W-1:0] next_trim;
    ctu_pkg::ctu_range_t next_range;

    // Reset release through two flops
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rst_pipe <= 2'h0;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end
    assign rst_sync_n = rst_pipe[1];

    ctu_sync2 u_sync (
        .clock(clock),
        .rst_sync_n(rst_sync_n),
        .async_in({comparator_out, external_edge_input}),
        .sync_out(async_sync)
    );
    assign comp_s = async_sync[`CTU_ASYNC_W-1:`CTU_EXT_PINS];
    assign ext_s = async_sync[`CTU_EXT_PINS-1:0];

    // Source code maps, index is the 4-bit select code
    assign first_levels = {comp_s[2], comp_s[1], comp_s[0], clc2_out, clc1_out, ccp2_event,
                           ext_s[7], ext_s[6], ext_s[5], ext_s[4], ext_s[3], ext_s[2],
                           ext_s[0], ext_s[1], ccp1_event, timer1_event};
    assign second_levels = {comp_s[2], comp_s[1], comp_s[0], 1'b0, clc1_out, ccp2_event,
                            1'b0, ext_s[12], ext_s[11], ext_s[10], ext_s[9], ext_s[8],
                            ext_s[0], ext_s[1], ccp1_event, timer1_event};

    // Delay mode takes comparator 2 rising as the second edge
    always_comb
    begin
        second_cfg_eff = second_cfg;
        if (ctrl_low.delay_pulse_enable)
        begin
            second_cfg_eff.sensitivity = 1'b1;
            second_cfg_eff.polarity = 1'b1;
            second_cfg_eff.source = `CTU_SEL_COMP2;
        end
    end

    ctu_edge_chan u_first (
        .clock(clock),
        .rst_sync_n(rst_sync_n),
        .levels(first_levels),
        .cfg(first_cfg),
        .hit(hit_first)
    );

    ctu_edge_chan u_second (
        .clock(clock),
        .rst_sync_n(rst_sync_n),
        .levels(second_levels),
        .cfg(second_cfg_eff),
        .hit(hit_second)
    );

    assign halted = ctrl_low.idle_stop && idle_mode;
    assign active = ctrl_low.unit_enable && !halted;
    assign qual_first = active && ctrl_low.edge_gate && hit_first;
    assign qual_second = active && ctrl_low.edge_gate && hit_second
                         && (!ctrl_low.edge_order_enforce || first_edge_seen);

    // Bus decode
    assign wb_take = wb_req.cyc && wb_req.stb && !wb_ack_o;
    assign wr_low = wb_take && wb_req.we && (wb_req.adr == `CTU_ADDR_CTRL_LOW);
    assign wr_high = wb_take && wb_req.we && (wb_req.adr == `CTU_ADDR_CTRL_HIGH);
    assign byte_mask = {{8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
    assign ctrl_low_bits = ctrl_low;
    assign ctrl_high_bits = {first_cfg, second_edge_seen, first_edge_seen, second_cfg, 2'h0};
    assign status_bits = {auto_ground, halted, analog_ctl.source_grounded,
                          analog_ctl.source_on, pulse_out_pin};

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_take;
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            wb_dat_o <= {`CTU_DAT_W{1'b0}};
        else if (wb_take && !wb_req.we)
        begin
            if (wb_req.adr == `CTU_ADDR_CTRL_LOW)
                wb_dat_o <= {16'h0000, ctrl_low_bits};
            else if (wb_req.adr == `CTU_ADDR_CTRL_HIGH)
                wb_dat_o <= {16'h0000, ctrl_high_bits};
            else if (wb_req.adr == `CTU_ADDR_STATUS)
                wb_dat_o <= {27'h0000000, status_bits};
            else
                wb_dat_o <= {`CTU_DAT_W{1'b0}};
        end
    end

    // Control registers
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            ctrl_low <= `CTU_CTRL_LOW_RESET;
        else if (wr_low)
            ctrl_low <= (ctrl_low_bits & ~byte_mask)
                        | (wb_req.dat[15:0] & byte_mask & `CTU_CTRL_LOW_MASK);
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            first_cfg <= 6'(`CTU_CTRL_HIGH_RESET >> 10);
            second_cfg <= 6'(`CTU_CTRL_HIGH_RESET >> 2);
        end
        else if (wr_high)
        begin
            if (wb_req.sel[1])
                first_cfg <= wb_req.dat[15:10];
            if (wb_req.sel[0])
                second_cfg <= wb_req.dat[7:2];
        end
    end

    // Edge seen flags: hardware set wins over a software write
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            first_edge_seen <= 1'b0;
        else if (qual_first)
            first_edge_seen <= 1'b1;
        else if (wr_high && wb_req.sel[1])
            first_edge_seen <= wb_req.dat[8];
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            second_edge_seen <= 1'b0;
        else if (qual_second)
            second_edge_seen <= 1'b1;
        else if (wr_high && wb_req.sel[1])
            second_edge_seen <= wb_req.dat[9];
    end

    // Trip grounds the source until the next first edge or until delay mode is switched off
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            auto_ground <= 1'b0;
        else if (ctrl_low.delay_pulse_enable && qual_second)
            auto_ground <= 1'b1;
        else if (qual_first || !ctrl_low.delay_pulse_enable)
            auto_ground <= 1'b0;
    end

    // Analog steering and pulse
    always_comb
    begin
        next_grounded = ctrl_low.source_ground || auto_ground || !active;
        next_pulse = active && first_edge_seen && !second_edge_seen;
        next_trim = ctrl_low.current_trim;
        if (ctrl_low.current_trim == `CTU_TRIM_UNLISTED)
            next_trim = `CTU_TRIM_MAX_NEG;
        case (ctrl_low.current_range)
            2'h1: next_range = ctu_pkg::CTU_RANGE_BASE;
            2'h2: next_range = ctu_pkg::CTU_RANGE_X10;
            2'h3: next_range = ctu_pkg::CTU_RANGE_X100;
            default: next_range = ctu_pkg::CTU_RANGE_X1000;
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            pulse_out_pin <= 1'b0;
        else
            pulse_out_pin <= next_pulse;
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            trigger_out <= 1'b0;
        else
            trigger_out <= ctrl_low.trigger_out_enable && qual_second;
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            analog_ctl.unit_active <= 1'b0;
            analog_ctl.source_on <= 1'b0;
            analog_ctl.source_grounded <= 1'b1;
            analog_ctl.route_comp2_b <= 1'b0;
            analog_ctl.range <= ctu_pkg::CTU_RANGE_X1000;
            analog_ctl.trim <= 6'h00;
        end
        else
        begin
            analog_ctl.unit_active <= active;
            analog_ctl.source_on <= next_pulse && !next_grounded;
            analog_ctl.source_grounded <= next_grounded;
            analog_ctl.route_comp2_b <= ctrl_low.delay_pulse_enable;
            analog_ctl.range <= next_range;
            analog_ctl.trim <= next_trim;
        end
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_sync_n);

    sequence trip_s;
        ctrl_low.delay_pulse_enable && qual_second;
    endsequence

    sequence grounded_low_s;
        (second_edge_seen && auto_ground) ##1 (!pulse_out_pin && analog_ctl.source_grounded);
    endsequence

    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property (wb_take |=> wb_ack_o)
        else $error("ack not one cycle after request");
    edge_block_a: assert property ((!ctrl_low.edge_gate && !wr_high) |=> $stable(first_edge_seen))
        else $error("first edge recorded while edges blocked");
    order_hold_a: assert property ((ctrl_low.edge_order_enforce && !first_edge_seen && !wr_high)
                                   |=> !$rose(second_edge_seen))
        else $error("second edge before first edge");
    ground_tie_a: assert property (ctrl_low.source_ground
                                   |=> analog_ctl.source_grounded && !analog_ctl.source_on)
        else $error("source not grounded");
    trig_gate_a: assert property (!ctrl_low.trigger_out_enable |=> !trigger_out)
        else $error("trigger out while disabled");
    range_kilo_a: assert property ((ctrl_low.current_range == 2'h0)
                                   |=> analog_ctl.range == ctu_pkg::CTU_RANGE_X1000)
        else $error("range 00 not thousand times");
    pulse_width_a: assert property (pulse_out_pin
                                    == $past(active && first_edge_seen && !second_edge_seen))
        else $error("pulse does not follow edge interval");
    trip_ground_a: assert property (trip_s |=> grounded_low_s)
        else $error("comparator trip did not end pulse and ground source");
    unit_off_a: assert property (!ctrl_low.unit_enable
                                 |=> !analog_ctl.source_on && !pulse_out_pin)
        else $error("unit acts while disabled");
    idle_halt_a: assert property ((ctrl_low.idle_stop && idle_mode)
                                  |=> !analog_ctl.unit_active)
        else $error("unit runs in idle with idle stop");
    route_delay_a: assert property (ctrl_low.delay_pulse_enable |=> analog_ctl.route_comp2_b)
        else $error("delay mode did not route source to comparator 2");
    charge_start_a: assert property (qual_first ##1 (ctrl_low.delay_pulse_enable && active
                                     && !ctrl_low.source_ground && !auto_ground
                                     && !second_edge_seen) |=> analog_ctl.source_on)
        else $error("first edge did not start charging");

endmodule
`default_nettype wire

//--- sim/ctu_edge_src_model.sv
// Edge source model: external pins, comparators and internal event levels
`timescale 1ns/1ps
`default_nettype none
`include "ctu_params.svh"

module ctu_edge_src_model (
    // Clock
    input wire logic clock,
    // Source levels
    output logic [`CTU_EXT_PINS-1:0] external_edge_input,
    output logic [`CTU_COMPS-1:0] comparator_out,
    output logic [4:0] internal_src
);
    // Index 0..12 pins, 13..15 comparators, 16 timer, 17..18 compare flags, 19..20 logic cells
    logic [20:0] lv = 21'h000000;

    assign external_edge_input = lv[12:0];
    assign comparator_out = lv[15:13];
    assign internal_src = lv[20:16];

    // Sources only move just after a rising edge
    task automatic set_src(input int idx, input logic v);
        @(posedge clock);
        lv[idx] <= v;
    endtask
endmodule
`default_nettype wire

//--- sim/ctu_charge_timing_unit_tb.sv
// Self-checking bench for the charge timing unit
`timescale 1ns/1ps
`default_nettype none
`include "ctu_params.svh"

module ctu_charge_timing_unit_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic idle_mode = 1'b0;
    ctu_pkg::ctu_wb_req_t wb_req = '0;
    logic [`CTU_DAT_W-1:0] wb_dat_o;
    logic wb_ack_o;
    logic pulse_out_pin;
    logic trigger_out;
    ctu_pkg::ctu_analog_t analog_ctl;
    logic [`CTU_EXT_PINS-1:0] ext_pins;
    logic [`CTU_COMPS-1:0] comps;
    logic [4:0] internal_src;
    int fail_count = 0;
    int n_checks = 0;
    int hi_cycles = 0;
    int trig_cnt = 0;
    int cyc_cnt = 0;
    logic [1:0] rng_code [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    logic [3:0] rng_hot [4] = '{4'h8, 4'h1, 4'h2, 4'h4};
    logic [5:0] trim_code [5] = '{6'h00, 6'h1F, 6'h01, 6'h3F, 6'h21};
    logic [3:0] src_code [5] = '{4'h0, 4'h1, 4'hB, 4'hF, 4'h3};
    int src_idx [5] = '{16, 17, 19, 15, 0};

    always #10 clock = ~clock;

    ctu_edge_src_model src (
        .clock(clock),
        .external_edge_input(ext_pins),
        .comparator_out(comps),
        .internal_src(internal_src)
    );

    ctu_charge_timing_unit uut (
        .clock(clock), .rst_n(rst_n),
        .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .idle_mode(idle_mode),
        .timer1_event(internal_src[0]), .ccp1_event(internal_src[1]),
        .ccp2_event(internal_src[2]), .clc1_out(internal_src[3]),
        .clc2_out(internal_src[4]),
        .comparator_out(comps), .external_edge_input(ext_pins),
        .pulse_out_pin(pulse_out_pin), .trigger_out(trigger_out),
        .analog_ctl(analog_ctl)
    );

    task automatic complete_run();
        $display("Checks made: %0d, mismatches: %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Pulse width, trigger count and hang limit
    always @(posedge clock)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (pulse_out_pin === 1'b1)
            hi_cycles <= hi_cycles + 1;
        if (trigger_out === 1'b1)
            trig_cnt <= trig_cnt + 1;
        if (cyc_cnt == 20000)
        begin
            fail_count = fail_count + 1;
            complete_run();
        end
    end

    task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] register %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_sig(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] signal %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Classic single cycle; holds the request until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [15:0] wd,
                           output logic [31:0] rdat);
        @(posedge clock);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h3, dat: {16'h0000, wd}};
        do
            @(posedge clock);
        while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_req <= '0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [15:0] wd);
        logic [31:0] dummy;
        wb_xfer(1'b1, adr, wd, dummy);
    endtask

    task automatic rdc(input string nm, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] got;
        wb_xfer(1'b0, adr, 16'h0000, got);
        chk_reg(nm, exp, got);
    endtask

    // First-channel edge on pin 1, second on pin 2 after gap cycles
    task automatic two_edges(input int gap);
        src.set_src(0, 1'b1);
        repeat (gap - 1) @(posedge clock);
        src.set_src(1, 1'b1);
        repeat (10) @(posedge clock);
        src.set_src(0, 1'b0);
        src.set_src(1, 1'b0);
        repeat (6) @(posedge clock);
    endtask

    initial
    begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rdc("ctrl_low", `CTU_ADDR_CTRL_LOW, 32'h00000000);
        rdc("ctrl_high", `CTU_ADDR_CTRL_HIGH, 32'h00000000);
        rdc("status", `CTU_ADDR_STATUS, 32'h00000004);
        rdc("unmapped", 8'h0C, 32'h00000000);
        chk_sig("range", 32'h00000008, {28'h0000000, analog_ctl.range});
        $display("test reset_values done");

        wr(`CTU_ADDR_CTRL_LOW, 16'hFFFF);
        rdc("ctrl_low", `CTU_ADDR_CTRL_LOW, 32'h0000BFFF);
        for (int i = 0; i < 5; i++)
        begin
            wr(`CTU_ADDR_CTRL_LOW, {8'h80, trim_code[i], rng_code[i % 4]});
            repeat (2) @(posedge clock);
            chk_sig("range", {28'h0000000, rng_hot[i % 4]}, {28'h0000000, analog_ctl.range});
            chk_sig("trim", {26'h0000000, trim_code[i]}, {26'h0000000, analog_ctl.trim});
        end
        chk_sig("active", 32'h00000001, {31'h00000000, analog_ctl.unit_active});
        wr(`CTU_ADDR_CTRL_LOW, 16'h8201);
        repeat (2) @(posedge clock);
        chk_sig("grounded", 32'h00000001, {31'h00000000, analog_ctl.source_grounded});
        wr(`CTU_ADDR_CTRL_LOW, 16'h8001);
        repeat (2) @(posedge clock);
        chk_sig("grounded", 32'h00000000, {31'h00000000, analog_ctl.source_grounded});
        wr(`CTU_ADDR_CTRL_LOW, 16'h0001);
        repeat (2) @(posedge clock);
        chk_sig("active", 32'h00000000, {31'h00000000, analog_ctl.unit_active});
        $display("test control_fields done");

        // Both channels edge sensitive before edges open; channel 2 on a dead code
        wr(`CTU_ADDR_CTRL_HIGH, 16'hC0E4);
        wr(`CTU_ADDR_CTRL_LOW, 16'h8801);
        for (int i = 0; i < 5; i++)
        begin
            wr(`CTU_ADDR_CTRL_HIGH, {2'h3, src_code[i], 2'h0, 8'hE4});
            src.set_src(src_idx[i], 1'b1);
            repeat (6) @(posedge clock);
            rdc("ctrl_high", `CTU_ADDR_CTRL_HIGH, {16'h0000, 2'h3, src_code[i], 2'h1, 8'hE4});
            src.set_src(src_idx[i], 1'b0);
            repeat (4) @(posedge clock);
        end
        $display("test edge_sources done");

        wr(`CTU_ADDR_CTRL_HIGH, 16'hCCC8);
        wr(`CTU_ADDR_CTRL_LOW, 16'h8501);
        src.set_src(0, 1'b1);
        repeat (8) @(posedge clock);
        chk_sig("pulse", 32'h00000000, {31'h00000000, pulse_out_pin});
        src.set_src(0, 1'b0);
        repeat (4) @(posedge clock);
        wr(`CTU_ADDR_CTRL_LOW, 16'h8D01);
        src.set_src(1, 1'b1);
        repeat (8) @(posedge clock);
        rdc("ctrl_high", `CTU_ADDR_CTRL_HIGH, 32'h0000CCC8);
        src.set_src(1, 1'b0);
        repeat (4) @(posedge clock);
        hi_cycles = 0;
        trig_cnt = 0;
        two_edges(10);
        chk_sig("pulse width", 32'h0000000A, hi_cycles);
        chk_sig("trigger count", 32'h00000001, trig_cnt);
        rdc("ctrl_high", `CTU_ADDR_CTRL_HIGH, 32'h0000CFC8);
        $display("test measurement done");

        wr(`CTU_ADDR_CTRL_HIGH, 16'hCCC8);
        wr(`CTU_ADDR_CTRL_LOW, 16'hAC01);
        idle_mode <= 1'b1;
        hi_cycles = 0;
        two_edges(5);
        chk_sig("idle pulse width", 32'h00000000, hi_cycles);
        idle_mode <= 1'b0;
        wr(`CTU_ADDR_CTRL_HIGH, 16'hCCC8);
        hi_cycles = 0;
        trig_cnt = 0;
        two_edges(5);
        chk_sig("pulse width", 32'h00000005, hi_cycles);
        chk_sig("trigger count", 32'h00000000, trig_cnt);
        $display("test idle_and_trigger done");

        wr(`CTU_ADDR_CTRL_HIGH, 16'hCC00);
        wr(`CTU_ADDR_CTRL_LOW, 16'h9900);
        repeat (2) @(posedge clock);
        chk_sig("route", 32'h00000001, {31'h00000000, analog_ctl.route_comp2_b});
        src.set_src(0, 1'b1);
        repeat (6) @(posedge clock);
        chk_sig("pulse", 32'h00000001, {31'h00000000, pulse_out_pin});
        chk_sig("source on", 32'h00000001, {31'h00000000, analog_ctl.source_on});
        src.set_src(14, 1'b1);
        repeat (6) @(posedge clock);
        chk_sig("pulse", 32'h00000000, {31'h00000000, pulse_out_pin});
        chk_sig("source on", 32'h00000000, {31'h00000000, analog_ctl.source_on});
        rdc("status", `CTU_ADDR_STATUS, 32'h00000014);
        $display("test delay_mode done");

        // Pin 1 still high: channel 1 falling edge, channel 2 level high on pin 2
        wr(`CTU_ADDR_CTRL_LOW, 16'h0001);
        wr(`CTU_ADDR_CTRL_HIGH, 16'h8C48);
        wr(`CTU_ADDR_CTRL_LOW, 16'h8801);
        repeat (6) @(posedge clock);
        rdc("ctrl_high", `CTU_ADDR_CTRL_HIGH, 32'h00008C48);
        src.set_src(0, 1'b0);
        src.set_src(1, 1'b1);
        repeat (6) @(posedge clock);
        rdc("ctrl_high", `CTU_ADDR_CTRL_HIGH, 32'h00008F48);
        $display("test level_and_falling done");
        complete_run();
    end
endmodule
`default_nettype wire
